// >>> src/tcc_pkg.sv
`default_nettype none
package tcc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  TIMER_CTRL   = 4'h0;
  localparam logic [3:0]  COUNT_HIGH   = 4'h1;
  localparam logic [3:0]  COUNT_LOW    = 4'h2;
  localparam logic [3:0]  MOD_HIGH     = 4'h3;
  localparam logic [3:0]  MOD_LOW      = 4'h4;
  localparam logic [3:0]  CH0_CTL      = 4'h5;
  localparam logic [3:0]  CH0_VAL_HIGH = 4'h6;
  localparam logic [3:0]  CH0_VAL_LOW  = 4'h7;
  localparam logic [3:0]  CH_STRIDE    = 4'h3;

  // ****************************************************************
  // Timer control fields
  // ****************************************************************
  localparam int unsigned TC_FLAG  = 7;
  localparam int unsigned TC_HALT  = 5;
  localparam int unsigned TC_RESET = 4;

  // ****************************************************************
  // Channel control fields
  // ****************************************************************
  localparam int unsigned CC_FLAG = 7;
  localparam int unsigned CC_IE   = 6;
  localparam int unsigned CC_MSB  = 5;
  localparam int unsigned CC_MSA  = 4;
  localparam int unsigned CC_ELSB = 3;
  localparam int unsigned CC_ELSA = 2;
  localparam int unsigned CC_TOV  = 1;
  localparam int unsigned CC_MAX  = 0;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] MOD_RESET  = 16'hFFFF;
  localparam logic [7:0]  CTL_RESET  = 8'h00;
  localparam logic        HALT_RESET = 1'b1;

  // ****************************************************************
  // Pin action encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    TCC_ACT_NONE   = 2'b00,
    TCC_ACT_TOGGLE = 2'b01,
    TCC_ACT_CLEAR  = 2'b10,
    TCC_ACT_SET    = 2'b11
  } tcc_action_t;

endpackage
`default_nettype wire

// >>> src/tcc_timer.sv
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tcc_timer #(
  parameter int unsigned NUM_CH = 2
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       count_tick,
  input  wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  input  wire logic [1:0]                 channel_pin_in,
  output logic      [1:0]                 channel_pin_out,
  output logic      [1:0]                 channel_pin_oe_n,
  output logic      [1:0]                 channel_irq
);
  import tcc_pkg::*;

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (NUM_CH != 2) begin : g_bad_ch
    $error("tcc_timer serves exactly two linked channels");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0]      cnt;
    logic [7:0]       cnt_lo_buf;
    logic             cnt_lo_held;
    logic [15:0]      modulo;
    logic             mod_lock;
    logic             ovf_flag;
    logic             ovf_armed;
    logic             halt;
    logic [1:0][7:0]  ctl;
    logic [1:0]       flag_armed;
    logic [1:0][15:0] value;
    logic [1:0]       cap_lock;
    logic [1:0]       cmp_lock;
    logic [1:0]       pin_prev;
    logic [1:0]       pin_level;
    logic [1:0]       pin_oe_n;
    logic [1:0]       max_eff;
    logic             buf_sel;
    logic [1:0]       irq;
    logic [7:0]       rdata;
  } tcc_state_t;

  tcc_state_t st;
  tcc_state_t next_st;

  logic             tick_run;
  logic             ovf;
  logic             buffered;
  logic [1:0]       ch_active;
  logic [1:0]       compare_mode;
  logic [1:0]       capture_mode;
  logic [1:0]       cap_evt;
  logic [1:0]       cmp_evt;
  logic [1:0][1:0]  els;
  logic [1:0][15:0] cmp_val;
  logic [1:0]       cmp_locked;

  // ****************************************************************
  // Channel decode
  // ****************************************************************
  always_comb begin
    buffered = st.ctl[0][CC_MSB];
    tick_run = count_tick & ~st.halt;
    ovf      = tick_run & (st.cnt == st.modulo);
    for (int i = 0; i < 2; i++) begin
      els[i]          = {st.ctl[i][CC_ELSB], st.ctl[i][CC_ELSA]};
      ch_active[i]    = !((i == 1) && buffered);
      compare_mode[i] = st.ctl[i][CC_MSA] | ((i == 0) && buffered);
      capture_mode[i] = !compare_mode[i] && (els[i] != 2'b00);
      if ((i == 0) && buffered) begin
        cmp_val[i]    = st.value[st.buf_sel];
        cmp_locked[i] = st.cmp_lock[st.buf_sel];
      end else begin
        cmp_val[i]    = st.value[i];
        cmp_locked[i] = st.cmp_lock[i];
      end
      cap_evt[i] = ch_active[i] & capture_mode[i] & ~st.halt
                 & ~st.cap_lock[i]
                 & ((els[i][0] & channel_pin_in[i] & ~st.pin_prev[i])
                 | (els[i][1] & ~channel_pin_in[i] & st.pin_prev[i]));
      cmp_evt[i] = ch_active[i] & compare_mode[i] & tick_run
                 & (st.cnt == cmp_val[i]) & ~cmp_locked[i];
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st       = st;
    next_st.rdata = 8'h00;

    // Counter
    if (tick_run) begin
      next_st.cnt = ovf ? 16'h0000 : st.cnt + 16'h0001;
    end

    // Register reads; unmapped addresses read zero
    if (reg_rd) begin
      case (reg_addr)
        TIMER_CTRL: begin
          next_st.rdata[TC_FLAG] = st.ovf_flag;
          next_st.rdata[TC_HALT] = st.halt;
          if (st.ovf_flag) begin
            next_st.ovf_armed = 1'b1;
          end
        end
        COUNT_HIGH: begin
          next_st.rdata = st.cnt[15:8];
          if (!st.cnt_lo_held) begin
            next_st.cnt_lo_buf  = st.cnt[7:0];
            next_st.cnt_lo_held = 1'b1;
          end
        end
        COUNT_LOW: begin
          next_st.rdata       = st.cnt_lo_held ? st.cnt_lo_buf : st.cnt[7:0];
          next_st.cnt_lo_held = 1'b0;
        end
        MOD_HIGH: begin
          next_st.rdata = st.modulo[15:8];
        end
        MOD_LOW: begin
          next_st.rdata = st.modulo[7:0];
        end
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (reg_addr == CH0_CTL + CH_STRIDE * 4'(i)) begin
              next_st.rdata = st.ctl[i];
              if (st.ctl[i][CC_FLAG]) begin
                next_st.flag_armed[i] = 1'b1;
              end
            end
            if (reg_addr == CH0_VAL_HIGH + CH_STRIDE * 4'(i)) begin
              next_st.rdata = st.value[i][15:8];
              if (capture_mode[i]) begin
                next_st.cap_lock[i] = 1'b1;
              end
            end
            if (reg_addr == CH0_VAL_LOW + CH_STRIDE * 4'(i)) begin
              next_st.rdata       = st.value[i][7:0];
              next_st.cap_lock[i] = 1'b0;
            end
          end
        end
      endcase
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        TIMER_CTRL: begin
          next_st.halt = reg_wdata[TC_HALT];
          if (reg_wdata[TC_RESET]) begin
            next_st.cnt = 16'h0000;
          end
          if (!reg_wdata[TC_FLAG] && st.ovf_armed) begin
            next_st.ovf_flag  = 1'b0;
            next_st.ovf_armed = 1'b0;
          end
        end
        MOD_HIGH: begin
          next_st.modulo[15:8] = reg_wdata;
          next_st.mod_lock     = 1'b1;
        end
        MOD_LOW: begin
          next_st.modulo[7:0] = reg_wdata;
          next_st.mod_lock    = 1'b0;
        end
        default: begin
          for (int i = 0; i < 2; i++) begin
            if (reg_addr == CH0_CTL + CH_STRIDE * 4'(i)) begin
              next_st.ctl[i][6:0] = reg_wdata[6:0];
              if (i == 1) begin
                next_st.ctl[i][CC_MSB] = 1'b0;
              end
              if (!reg_wdata[CC_FLAG] && st.flag_armed[i]) begin
                next_st.ctl[i][CC_FLAG] = 1'b0;
                next_st.flag_armed[i]   = 1'b0;
              end
            end
            if (reg_addr == CH0_VAL_HIGH + CH_STRIDE * 4'(i)) begin
              next_st.value[i][15:8] = reg_wdata;
              if (compare_mode[i] || buffered) begin
                next_st.cmp_lock[i] = 1'b1;
              end
            end
            if (reg_addr == CH0_VAL_LOW + CH_STRIDE * 4'(i)) begin
              next_st.value[i][7:0] = reg_wdata;
              next_st.cmp_lock[i]   = 1'b0;
            end
          end
        end
      endcase
    end

    // Overflow flag; a new overflow beats a clearing write
    if (ovf && !st.mod_lock) begin
      next_st.ovf_flag  = 1'b1;
      next_st.ovf_armed = 1'b0;
    end

    // Buffered compare register alternates per period
    if (!buffered) begin
      next_st.buf_sel = 1'b0;
    end else if (ovf) begin
      next_st.buf_sel = ~st.buf_sel;
    end

    // Channels
    for (int i = 0; i < 2; i++) begin
      next_st.pin_prev[i] = channel_pin_in[i];
      if (cap_evt[i]) begin
        next_st.value[i] = st.cnt;
      end
      if (cap_evt[i] || cmp_evt[i]) begin
        next_st.ctl[i][CC_FLAG] = 1'b1;
        next_st.flag_armed[i]   = 1'b0;
      end
      if (!ch_active[i] || capture_mode[i]) begin
        next_st.pin_oe_n[i] = 1'b1;
      end else if (els[i] == 2'b00) begin
        // Preset level is held so the pin starts from it once connected
        next_st.pin_oe_n[i]  = 1'b1;
        next_st.pin_level[i] = ~st.ctl[i][CC_MSA];
      end else begin
        next_st.pin_oe_n[i] = 1'b0;
        if (ovf && st.ctl[i][CC_TOV]) begin
          // Full duty is sampled only here so it starts with a new period
          next_st.max_eff[i]   = st.ctl[i][CC_MAX];
          next_st.pin_level[i] = st.ctl[i][CC_MAX] | ~st.pin_level[i];
        end else if (cmp_evt[i] && !(st.ctl[i][CC_TOV] && st.max_eff[i])) begin
          case (tcc_action_t'(els[i]))
            TCC_ACT_TOGGLE: next_st.pin_level[i] = ~st.pin_level[i];
            TCC_ACT_CLEAR:  next_st.pin_level[i] = 1'b0;
            TCC_ACT_SET:    next_st.pin_level[i] = 1'b1;
            default:        next_st.pin_level[i] = st.pin_level[i];
          endcase
        end
      end
      next_st.irq[i] = next_st.ctl[i][CC_IE] & next_st.ctl[i][CC_FLAG];
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    st <= next_st;
    if (!rst_n) begin
      // Channel values keep whatever they hold
      st.cnt         <= 16'h0000;
      st.cnt_lo_buf  <= 8'h00;
      st.cnt_lo_held <= 1'b0;
      st.modulo      <= MOD_RESET;
      st.mod_lock    <= 1'b0;
      st.ovf_flag    <= 1'b0;
      st.ovf_armed   <= 1'b0;
      st.halt        <= HALT_RESET;
      st.ctl         <= {CTL_RESET, CTL_RESET};
      st.flag_armed  <= 2'b00;
      st.cap_lock    <= 2'b00;
      st.cmp_lock    <= 2'b00;
      st.pin_prev    <= 2'b00;
      st.pin_level   <= 2'b11;
      st.pin_oe_n    <= 2'b11;
      st.max_eff     <= 2'b00;
      st.buf_sel     <= 1'b0;
      st.irq         <= 2'b00;
      st.rdata       <= 8'h00;
    end
  end

  assign reg_rdata        = st.rdata;
  assign channel_pin_out  = st.pin_level;
  assign channel_pin_oe_n = st.pin_oe_n;
  assign channel_irq      = st.irq;

endmodule
`default_nettype wire

// >>> tb/tcc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_asserts #(
  parameter int unsigned NUM_CH = 2
) (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic                       count_tick,
  input wire logic [tcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                 reg_wdata,
  input wire logic                       reg_wr,
  input wire logic                       reg_rd,
  input wire logic [7:0]                 reg_rdata,
  input wire logic [1:0]                 channel_pin_in,
  input wire logic [1:0]                 channel_pin_out,
  input wire logic [1:0]                 channel_pin_oe_n,
  input wire logic [1:0]                 channel_irq
);
  import tcc_pkg::*;
  // ************
  // Shadow state
  // ************
  logic [7:0] ctl0;
  logic       halt;
  wire logic  w0 = reg_wr && reg_addr == CH0_CTL;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl0 <= CTL_RESET;
      halt <= HALT_RESET;
    end else if (reg_wr) begin
      if (reg_addr == CH0_CTL) ctl0 <= reg_wdata;
      if (reg_addr == TIMER_CTRL) halt <= reg_wdata[TC_HALT];
    end
  end
  // **********
  // Properties
  // **********
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_reset_outs: assert property (!$past(rst_n) |-> &channel_pin_oe_n && !channel_irq)
    else $error("outputs wrong after reset");
  a_irq_enable: assert property (channel_irq[0] |-> ctl0[CC_IE] || $past(ctl0[CC_IE]))
    else $error("irq without enable");
  a_irq_clear: assert property ($fell(channel_irq[0]) |-> $past(w0) || $past(w0, 2))
    else $error("irq dropped without control write");
  a_buf_frees: assert property (ctl0[CC_MSB] && $past(ctl0[CC_MSB]) |-> channel_pin_oe_n[1])
    else $error("channel 1 pin still driven");
  a_preset_lvl: assert property (ctl0[3:2] == 2'b00 && $stable(ctl0)
    |-> channel_pin_oe_n[0] && channel_pin_out[0] == !ctl0[CC_MSA])
    else $error("preset level wrong");
  a_capture_hiz: assert property (ctl0[5:4] == 2'b00 && ctl0[3:2] != 2'b00
    && $stable(ctl0) |-> channel_pin_oe_n[0])
    else $error("capture pin driven");
  a_compare_drv: assert property (ctl0[5:4] != 2'b00 && ctl0[3:2] != 2'b00
    && $stable(ctl0) |-> !channel_pin_oe_n[0])
    else $error("compare pin not driven");
  a_halt_hold: assert property (halt && $past(halt) && $past(halt, 2) && $stable(ctl0)
    && $past(ctl0, 2) == ctl0 |-> $stable(channel_pin_out[0]))
    else $error("pin moved while halted");
  c_irq: cover property (channel_irq[0]);
  c_toggle: cover property ($rose(channel_pin_out[0]) && !channel_pin_oe_n[0]);
  c_buffered: cover property (ctl0[CC_MSB] && channel_pin_oe_n[1]);
endmodule
bind tcc_timer tcc_asserts #(.NUM_CH(NUM_CH)) u_asserts (
  .clk(clk), .rst_n(rst_n), .count_tick(count_tick), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
  .channel_pin_oe_n(channel_pin_oe_n), .channel_irq(channel_irq));
`default_nettype wire

// >>> tb/tcc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model (
  input  wire logic       clk,
  input  wire logic [1:0] level,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe_n,
  output logic      [1:0] pin_in
);
  // **************
  // External lines
  // **************
  logic [1:0] ext;
  // Edges land one clock late, as a slow source would
  always_ff @(posedge clk) ext <= level;
  // Block wins the wire while its enable is low
  assign pin_in = (pin_oe_n & ext) | (~pin_oe_n & pin_out);
endmodule
`default_nettype wire

// >>> tb/tcc_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_bench;
  import tcc_pkg::*;
  // *******
  // Harness
  // *******
  logic       clk, rst_n, tick, wr, rd;
  logic [3:0] addr;
  logic [7:0] wd, rdata, act, tmp;
  logic [7:0] sd = 8'h57;
  logic [1:0] pin_in, pin_out, oe_n, irq, lvl;
  logic [7:0] cfg[$] = '{8'h54, 8'h58, 8'h5C, 8'h56, 8'h57};
  int         cnt, md, v, n_tests, miscompares;
  bit         pin, ovf, lock, mx, hit;
  tcc_timer #(.NUM_CH(2)) DUT (
    .clk(clk), .rst_n(rst_n), .count_tick(tick), .reg_addr(addr), .reg_wdata(wd),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .channel_pin_in(pin_in),
    .channel_pin_out(pin_out), .channel_pin_oe_n(oe_n), .channel_irq(irq));
  tcc_pin_model u_pins (
    .clk(clk), .level(lvl), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // *****
  // Tasks
  // *****
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd8(input logic [3:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd8(a, d);
    chk(d, e);
  endtask
  task automatic ctrl(input logic [7:0] d);
    wr8(TIMER_CTRL, d);
    if (d[TC_RESET]) cnt = 0;
  endtask
  function automatic void step();
    bit o;
    bit c;
    o = cnt == md;
    c = cnt == v;
    cnt = o ? 0 : cnt + 1;
    if (o && !lock) ovf = 1;
    if (c) hit = 1;
    if (act[CC_TOV] && o) begin
      mx = act[CC_MAX];
      pin = mx | !pin;
    end else if (c && !mx) begin
      case (act[3:2])
        2'b01: pin = !pin;
        2'b10: pin = 0;
        2'b11: pin = 1;
        default: ;
      endcase
    end
  endfunction
  task automatic run(input int n);
    repeat (n) begin
      sd = {sd[6:0], sd[7] ^ sd[5] ^ sd[4] ^ sd[3]};
      tick <= sd[0];
      if (sd[0]) step();
      @(posedge clk);
    end
    tick <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Whole sequence is about 730 cycles; over twenty-five times that means a hang
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  // ********
  // Sequence
  // ********
  initial begin
    rst_n = 1'b0;
    tick = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wd = 8'h00;
    lvl = 2'b00;
    act = 8'h00;
    md = 'hFFFF;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(MOD_HIGH, 8'hFF);
    rc(MOD_LOW, 8'hFF);
    rc(TIMER_CTRL, 8'h20);
    wr8(4'hF, 8'h5A);
    rc(4'hF, 8'h00);
    chk(oe_n, 2'b11);
    $display("reset test done");
    wr8(MOD_HIGH, 8'h00);
    wr8(MOD_LOW, 8'h0B);
    md = 11;
    ctrl(8'h10);
    run(80);
    rc(COUNT_HIGH, cnt[15:8]);
    rc(COUNT_LOW, cnt[7:0]);
    rc(TIMER_CTRL, {ovf, 7'h00});
    ctrl(8'h00);
    rc(TIMER_CTRL, 8'h00);
    ovf = 0;
    lock = 1;
    ctrl(8'h10);
    wr8(MOD_HIGH, 8'h00);
    run(40);
    rc(TIMER_CTRL, 8'h00);
    wr8(MOD_LOW, 8'h0B);
    lock = 0;
    run(30);
    rc(TIMER_CTRL, {ovf, 7'h00});
    $display("counter test done");
    ctrl(8'h30);
    wr8(CH0_CTL, 8'h10);
    run(0);
    chk(pin_out[0], 1'b0);
    foreach (cfg[i]) begin
      ctrl(8'h30);
      v = cfg[i] == 8'h56 ? md : 5;
      wr8(CH0_VAL_HIGH, 8'h00);
      wr8(CH0_VAL_LOW, v[7:0]);
      act = cfg[i];
      wr8(CH0_CTL, act);
      ctrl(8'h00);
      run(60);
      chk(pin_out[0], pin);
    end
    chk(irq[0], hit);
    // A clear without the read first must not drop the flag
    wr8(CH0_CTL, act);
    rc(CH0_CTL, {hit, act[6:0]});
    wr8(CH0_CTL, act | 8'h80);
    rc(CH0_CTL, act | 8'h80);
    wr8(CH0_CTL, act);
    rc(CH0_CTL, act);
    chk(irq[0], 1'b0);
    $display("compare test done");
    run(25);
    for (int e = 1; e < 4; e++) begin
      wr8(CH0_CTL, 8'(e << 2));
      // Released pin may show a false edge; let it flag before clearing
      repeat (2) @(posedge clk);
      rd8(CH0_CTL, tmp);
      wr8(CH0_CTL, 8'(e << 2));
      for (int k = 0; k < 2; k++) begin
        lvl <= k ? 2'b00 : 2'b01;
        repeat (6) @(posedge clk);
        rc(CH0_CTL, {e[k], 7'(e << 2)});
        wr8(CH0_CTL, 8'(e << 2));
      end
    end
    rc(CH0_VAL_HIGH, cnt[15:8]);
    lvl <= 2'b01;
    repeat (6) @(posedge clk);
    rc(CH0_CTL, 8'h0C);
    rc(CH0_VAL_LOW, cnt[7:0]);
    ctrl(8'h20);
    lvl <= 2'b00;
    repeat (6) @(posedge clk);
    rc(CH0_CTL, 8'h0C);
    $display("capture test done");
    wr8(CH0_CTL + CH_STRIDE, 8'h54);
    run(0);
    chk(oe_n[1], 1'b0);
    wr8(CH0_CTL, 8'h24);
    run(0);
    chk(oe_n, 2'b10);
    chk(irq[1], 1'b0);
    $display("buffered test done");
    stop_test();
  end
endmodule
`default_nettype wire
